// ==== logic/pwm_hall_pkg.sv ====
package pwm_hall_pkg;

    // ------------------------------------------------------------
    // Widths and mode codes
    // ------------------------------------------------------------
    localparam int TMR_W  = 16;
    localparam int ADDR_W = 4;
    localparam int NCH    = 3;

    typedef logic [3:0] mode_t;

    localparam mode_t MODE_HALL  = 4'h8;
    localparam mode_t MODE_HYST  = 4'h9;
    localparam mode_t MODE_MC_RF = 4'hA;  // Pin rise, position fall
    localparam mode_t MODE_MC_FR = 4'hB;  // Pin fall, position rise
    localparam mode_t MODE_MC_RR = 4'hC;  // Pin rise, position rise
    localparam mode_t MODE_MC_FF = 4'hD;  // Pin fall, position fall
    localparam mode_t MODE_MC_AA = 4'hE;  // Any edge on both
    localparam mode_t MODE_RSVD  = 4'hF;  // No capture, no compare

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_MODE    = 4'h0;
    localparam logic [3:0] OFS_CC0     = 4'h1;
    localparam logic [3:0] OFS_CC1     = 4'h2;
    localparam logic [3:0] OFS_CC2     = 4'h3;
    localparam logic [3:0] OFS_PATTERN = 4'h4;
    localparam logic [3:0] OFS_SHADOW0 = 4'h5;
    localparam logic [3:0] OFS_STATUS  = 4'h8;
    localparam logic [3:0] OFS_TIMER   = 4'h9;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [2:0]  RST_PATTERN   = 3'h0;
    localparam logic [5:0]  HALL_DT_LOAD  = 6'h08;
    localparam logic [5:0]  HALL_SAMPLE_AT = 6'h01;

endpackage

// ==== logic/cap_if.sv ====
`timescale 1ns/1ns
// Shared view of timer, modes and sampled inputs
interface cap_if;
    logic [15:0]      timer;
    logic [2:0][3:0]  modes;
    logic [2:0]       pin;
    logic [2:0]       pin_prev;
    logic [2:0]       pos;
    logic [2:0]       pos_prev;

    modport src (output timer, modes, pin, pin_prev, pos, pos_prev);
    modport snk (input  timer, modes, pin, pin_prev, pos, pos_prev);
endinterface

// ==== logic/hall_filter.sv ====
`timescale 1ns/1ns
module hall_filter #(
    parameter logic [5:0] DT_LOAD = pwm_hall_pkg::HALL_DT_LOAD
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Shared inputs
    cap_if.snk              cif,
    input  wire logic       enable_i,
    // Filtered sample
    output logic            sample_stb_o,
    output logic [2:0]      sample_o
);
    import pwm_hall_pkg::*;

    logic [5:0] cnt;
    wire        any_edge = enable_i && (cif.pos != cif.pos_prev);
    wire        at_sample = (cnt == HALL_SAMPLE_AT);

    // Each new edge restarts the count; an edge landing in the count-one cycle is still sampled
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt          <= 6'h00;
            sample_stb_o <= 1'b0;
            sample_o     <= RST_PATTERN;
        end else begin
            sample_stb_o <= at_sample && enable_i;
            if (at_sample)
                sample_o <= cif.pos;
            if (any_edge)
                cnt <= DT_LOAD;
            else if (cnt != 6'h00)
                cnt <= cnt - 6'h01;
        end
    end

    property p_sample_at_one;
        @(posedge clk_i) disable iff (srst_i)
        (at_sample && enable_i) |=> sample_stb_o && (sample_o == $past(cif.pos));
    endproperty
    a_sample_at_one: assert property (p_sample_at_one)
        else $error("hall sample not taken at count one");
endmodule

// ==== logic/edge_capture.sv ====
`timescale 1ns/1ns
module edge_capture (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Shared inputs
    cap_if.snk               cif,
    // Capture results
    output logic [2:0]       main_hit_o,
    output logic [2:0][15:0] shadow_o
);
    import pwm_hall_pkg::*;

    // Mode decode, shared by pin and position paths
    function automatic logic hit(input mode_t m, input logic r, input logic f,
                                 input logic main);
        logic up;
        logic dn;
        up = main ? (m == MODE_MC_RF || m == MODE_MC_RR)
                  : (m == MODE_MC_FR || m == MODE_MC_RR);
        dn = main ? (m == MODE_MC_FR || m == MODE_MC_FF)
                  : (m == MODE_MC_RF || m == MODE_MC_FF);
        return (up && r) || (dn && f) || (m == MODE_MC_AA && (r || f));
    endfunction

    genvar n;
    generate
        for (n = 0; n < NCH; n++) begin : g_ch
            wire pr = cif.pin[n] && !cif.pin_prev[n];
            wire pf = !cif.pin[n] && cif.pin_prev[n];
            wire qr = cif.pos[n] && !cif.pos_prev[n];
            wire qf = !cif.pos[n] && cif.pos_prev[n];
            wire sh = hit(cif.modes[n], qr, qf, 1'b0);

            assign main_hit_o[n] = hit(cif.modes[n], pr, pf, 1'b1);

            // Shadow takes the timer on the selected position edge
            always_ff @(posedge clk_i) begin
                if (srst_i)
                    shadow_o[n] <= RST_WORD;
                else if (sh)
                    shadow_o[n] <= cif.timer;
            end

            property p_main_rise;
                @(posedge clk_i) disable iff (srst_i)
                ((cif.modes[n] == MODE_MC_RF || cif.modes[n] == MODE_MC_RR) && pr)
                |-> main_hit_o[n];
            endproperty
            a_main_rise: assert property (p_main_rise)
                else $error("pin rise did not capture");

            property p_shadow_fall;
                @(posedge clk_i) disable iff (srst_i)
                ((cif.modes[n] == MODE_MC_RF || cif.modes[n] == MODE_MC_FF) && qf)
                |=> shadow_o[n] == $past(cif.timer);
            endproperty
            a_shadow_fall: assert property (p_shadow_fall)
                else $error("position fall did not fill shadow");

            property p_reserved;
                @(posedge clk_i) disable iff (srst_i)
                (cif.modes[n] == MODE_RSVD) |=> !$past(main_hit_o[n])
                    && $stable(shadow_o[n]);
            endproperty
            a_reserved: assert property (p_reserved)
                else $error("reserved mode captured");
        end
    endgenerate
endmodule

// ==== logic/pwm_timer_hall_multi_capture.sv ====
// How it works
// - Hall code makes channel 0 capture and channels 1 and 2 compare.
// - Valid hall event captures timer into channel 0 register, then clears timer.
// - Channel 1 compare gives phase delay from hall event to output switching.
// - Channel 2 compare fires a time-out when the hall event is late.
// - Hall edge starts filter count; at one, inputs are sampled and compared.
// - Hysteresis mode: falling position edge clears state bit at once.
// - Hysteresis mode: state bit sets on compare only while position is high.
// - Multi-capture: pin edge of chosen polarity stores timer in main register.
// - Multi-capture: position edge of chosen polarity stores timer in shadow.
// - All-ones mode code does no capture and no compare.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
module pwm_timer_hall_multi_capture #(
    parameter logic [5:0] DT_LOAD = pwm_hall_pkg::HALL_DT_LOAD
) (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              srst_i,
    // Register port
    input  wire logic [pwm_hall_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [15:0]                       wdata_i,
    input  wire logic                              wr_i,
    input  wire logic                              rd_i,
    output logic      [15:0]                       rdata_o,
    // Channel pins and position inputs
    input  wire logic [2:0]                        chan_io_pin_i,
    input  wire logic [2:0]                        position_input_i,
    // Events and channel state
    output logic [2:0]                             chan_state_o,
    output logic                                   hall_evt_o,
    output logic                                   wrong_hall_o,
    output logic                                   phase_evt_o,
    output logic                                   timeout_evt_o
);
    import pwm_hall_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [11:0]      mode_reg;
    logic [2:0][15:0] capcomp;
    logic [15:0]      pwm_timer;
    logic [2:0]       cur_pat;
    logic [2:0]       exp_pat;
    logic [2:0]       pin_prev;
    logic [2:0]       pos_prev;
    logic             ph_armed;
    logic             to_armed;
    logic [2:0]       last_sample;

    logic [2:0]       main_hit;
    logic [2:0][15:0] shadow;
    logic             sample_stb;
    logic [2:0]       sample;

    // ------------------------------------------------------------
    // Shared view for the sub-blocks
    // ------------------------------------------------------------
    cap_if cif ();

    assign cif.timer    = pwm_timer;
    assign cif.modes    = mode_reg;
    assign cif.pin      = chan_io_pin_i;
    assign cif.pin_prev = pin_prev;
    assign cif.pos      = position_input_i;
    assign cif.pos_prev = pos_prev;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Hall edge detection runs only when every field holds the code;
    // a partly set map is an illegal setup and gets no hall activity.
    wire mode0_hall = (mode_reg[3:0] == MODE_HALL);
    wire hall_all   = mode0_hall && (mode_reg[7:4] == MODE_HALL)
                      && (mode_reg[11:8] == MODE_HALL);

    // Pattern check of a filtered sample
    wire pat_new     = sample_stb && (sample != cur_pat);
    wire hall_valid  = hall_all && pat_new && (sample == exp_pat);
    wire hall_wrong  = hall_all && pat_new && (sample != exp_pat);

    // Compare matches in hall mode, each fires once per hall event
    wire phase_hit   = hall_all && ph_armed
                       && (pwm_timer == capcomp[1]);
    wire timeout_hit = hall_all && to_armed
                       && (pwm_timer == capcomp[2]);

    // Software strobes
    wire wr_mode = wr_i && (addr_i == OFS_MODE);
    wire wr_pat  = wr_i && (addr_i == OFS_PATTERN);

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    hall_filter #(
        .DT_LOAD      (DT_LOAD)
    ) u_hall (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .cif          (cif),
        .enable_i     (hall_all),
        .sample_stb_o (sample_stb),
        .sample_o     (sample)
    );

    edge_capture u_cap (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .cif          (cif),
        .main_hit_o   (main_hit),
        .shadow_o     (shadow)
    );

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    // Free running; a valid hall event restarts it so the captured
    // value is the time between hall events
    always_ff @(posedge clk_i) begin
        if (srst_i)
            pwm_timer <= RST_WORD;
        else if (hall_valid)
            pwm_timer <= RST_WORD;
        else
            pwm_timer <= pwm_timer + 16'h0001;
    end

    // ------------------------------------------------------------
    // Input history for edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_prev <= 3'h0;
            pos_prev <= 3'h0;
        end else begin
            pin_prev <= chan_io_pin_i;
            pos_prev <= position_input_i;
        end
    end

    // ------------------------------------------------------------
    // Mode and pattern registers
    // ------------------------------------------------------------
    // Hardware update of the current pattern wins over a software write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_reg    <= 12'h000;
            cur_pat     <= RST_PATTERN;
            exp_pat     <= RST_PATTERN;
            last_sample <= RST_PATTERN;
        end else begin
            if (wr_mode)
                mode_reg <= wdata_i[11:0];
            if (wr_pat)
                exp_pat <= wdata_i[2:0];
            if (hall_valid)
                cur_pat <= sample;
            else if (wr_pat)
                cur_pat <= wdata_i[5:3];
            if (sample_stb)
                last_sample <= sample;
        end
    end

    // ------------------------------------------------------------
    // Capture/compare registers
    // ------------------------------------------------------------
    // A capture in the same cycle as a write keeps the capture; the
    // measured time matters more than a value software can rewrite.
    genvar n;
    generate
        for (n = 0; n < NCH; n++) begin : g_cc
            wire hw_store = main_hit[n] || (n == 0 && hall_valid);
            wire sw_store = wr_i && (addr_i == OFS_CC0 + 4'(n));
            always_ff @(posedge clk_i) begin
                if (srst_i)
                    capcomp[n] <= RST_WORD;
                else if (hw_store)
                    capcomp[n] <= pwm_timer;
                else if (sw_store)
                    capcomp[n] <= wdata_i;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Hysteresis-like channel state
    // ------------------------------------------------------------
    // Clearing is immediate; dead-time before the active level is
    // applied by the output stage that reads this state.
    generate
        for (n = 0; n < NCH; n++) begin : g_st
            wire hyst   = (mode_reg[4*n +: 4] == MODE_HYST);
            wire p_fall = pos_prev[n] && !position_input_i[n];
            wire cmp_ev = pwm_timer == capcomp[n];
            wire st_set = hyst && position_input_i[n] && cmp_ev;
            always_ff @(posedge clk_i) begin
                if (srst_i)
                    chan_state_o[n] <= 1'b0;
                else if (!hyst)
                    chan_state_o[n] <= 1'b0;
                else if (p_fall)
                    chan_state_o[n] <= 1'b0;
                else if (st_set)
                    chan_state_o[n] <= 1'b1;
            end

            property p_fall_clears;
                @(posedge clk_i) disable iff (srst_i)
                (hyst && p_fall) |=> !chan_state_o[n];
            endproperty
            a_fall_clears: assert property (p_fall_clears)
                else $error("falling position edge left state set");

            property p_set_cause;
                @(posedge clk_i) disable iff (srst_i)
                $rose(chan_state_o[n]) |-> $past(st_set);
            endproperty
            a_set_cause: assert property (p_set_cause)
                else $error("state set without compare and high position");
        end
    endgenerate

    // ------------------------------------------------------------
    // Hall events and compare triggers
    // ------------------------------------------------------------
    // Arming at the hall event makes each compare fire once, even
    // though the timer may wrap and pass the value again.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ph_armed      <= 1'b0;
            to_armed      <= 1'b0;
            hall_evt_o    <= 1'b0;
            wrong_hall_o  <= 1'b0;
            phase_evt_o   <= 1'b0;
            timeout_evt_o <= 1'b0;
        end else begin
            ph_armed      <= hall_valid || (ph_armed && !phase_hit);
            to_armed      <= hall_valid || (to_armed && !timeout_hit);
            hall_evt_o    <= hall_valid;
            wrong_hall_o  <= hall_wrong;
            phase_evt_o   <= phase_hit;
            timeout_evt_o <= timeout_hit;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Decoded each cycle, registered; unmapped offsets read zero
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = RST_WORD;
        case (addr_i)
            OFS_MODE:    next_rdata = {4'h0, mode_reg};
            OFS_CC0:     next_rdata = capcomp[0];
            OFS_CC1:     next_rdata = capcomp[1];
            OFS_CC2:     next_rdata = capcomp[2];
            OFS_PATTERN: next_rdata = {10'h000, cur_pat, exp_pat};
            OFS_SHADOW0: next_rdata = shadow[0];
            OFS_SHADOW0 + 4'h1: next_rdata = shadow[1];
            OFS_SHADOW0 + 4'h2: next_rdata = shadow[2];
            OFS_STATUS:  next_rdata = {10'h000, last_sample, chan_state_o};
            OFS_TIMER:   next_rdata = pwm_timer;
            default:     next_rdata = RST_WORD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            rdata_o <= RST_WORD;
        else if (rd_i)
            rdata_o <= next_rdata;
        else
            rdata_o <= RST_WORD;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hall_capture;
        @(posedge clk_i) disable iff (srst_i)
        hall_valid |=> (capcomp[0] == $past(pwm_timer)) && (pwm_timer == 16'h0000)
            && hall_evt_o;
    endproperty
    a_hall_capture: assert property (p_hall_capture)
        else $error("hall event did not capture and clear timer");

    property p_no_partial_hall;
        @(posedge clk_i) disable iff (srst_i)
        !hall_all |=> !hall_evt_o;
    endproperty
    a_no_partial_hall: assert property (p_no_partial_hall)
        else $error("hall event with incomplete hall setup");

    property p_ch0_capture;
        @(posedge clk_i) disable iff (srst_i)
        (mode0_hall && !hall_valid && !main_hit[0] && !(wr_i && addr_i == OFS_CC0))
        |=> $stable(capcomp[0]);
    endproperty
    a_ch0_capture: assert property (p_ch0_capture)
        else $error("channel 0 changed outside a hall capture");

    property p_phase;
        @(posedge clk_i) disable iff (srst_i)
        (hall_all && ph_armed && pwm_timer == capcomp[1] && !hall_valid)
        |=> phase_evt_o && !ph_armed;
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase delay compare missed");

    property p_timeout;
        @(posedge clk_i) disable iff (srst_i)
        timeout_evt_o |-> $past(to_armed) && ($past(pwm_timer) == $past(capcomp[2]));
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out fired without its compare");

    property p_valid_pattern;
        @(posedge clk_i) disable iff (srst_i)
        hall_evt_o |-> $past(sample != cur_pat) && $past(sample == exp_pat)
            && (cur_pat == $past(sample));
    endproperty
    a_valid_pattern: assert property (p_valid_pattern)
        else $error("hall event on a non-matching pattern");
endmodule

// ==== verif/hall_pin_model.sv ====
`timescale 1ns/1ns
module hall_pin_model (
    // Clock
    input  wire logic       clk_i,
    // Levels asked for by the bench
    input  wire logic [2:0] pin_req_i,
    input  wire logic [2:0] pos_req_i,
    // Levels seen by the timer
    output logic      [2:0] chan_io_pin_o,
    output logic      [2:0] position_input_o
);
    // Sensors switch only after a clock edge, never in mid-cycle
    always_ff @(posedge clk_i) begin
        chan_io_pin_o    <= pin_req_i;
        position_input_o <= pos_req_i;
    end
endmodule

// ==== verif/tb_pwm_timer_hall_multi_capture.sv ====
`timescale 1ns/1ns
module tb_pwm_timer_hall_multi_capture;
    import pwm_hall_pkg::*;
    localparam logic [5:0] DT = 6'h02;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [2:0] pin_req = 3'h0;
    logic [2:0] pos_req = 3'h0;
    logic [15:0] rdata_o;
    logic [2:0] pin_w, pos_w, chan_state_o;
    logic hall_evt_o, wrong_hall_o, phase_evt_o, timeout_evt_o;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 88331;
    // Capture times of the pin and position edges, per multi-capture mode A..E
    int mt[5] = '{0, 7, 0, 7, 7};
    int st[5] = '{12, 3, 3, 12, 12};
    logic [3:0] rst_ofs[5] = '{OFS_MODE, OFS_CC0, OFS_PATTERN, OFS_STATUS, 4'hF};
    logic [15:0] v, a, b;
    logic [3:0] m;
    int n;
    wire [3:0] evts = {timeout_evt_o, phase_evt_o, wrong_hall_o, hall_evt_o};

    hall_pin_model i_hall_pin_model (.clk_i(clk_i), .pin_req_i(pin_req), .pos_req_i(pos_req),
        .chan_io_pin_o(pin_w), .position_input_o(pos_w));
    pwm_timer_hall_multi_capture #(.DT_LOAD(DT)) i_pwm_timer_hall_multi_capture (
        .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .chan_io_pin_i(pin_w), .position_input_i(pos_w),
        .chan_state_o(chan_state_o), .hall_evt_o(hall_evt_o), .wrong_hall_o(wrong_hall_o),
        .phase_evt_o(phase_evt_o), .timeout_evt_o(timeout_evt_o));

    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic final_report();
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        addr_i  <= ad;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        // One idle edge, so a following write never re-raises the strobe in this step
        @(posedge clk_i);
    endtask

    // Strobe is taken at the first edge; data stands only in the following cycle
    task automatic rd(input logic [3:0] ad, output logic [15:0] d);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask

    // Bounded wait for an event pulse; a missing wanted event ends the run
    task automatic wait_evt(input int sel, input int lim, input bit want, output int cnt);
        bit got;
        got = 1'b0;
        for (cnt = 1; cnt <= lim && !got; cnt++) begin
            @(posedge clk_i);
            got = (evts[sel] === 1'b1);
        end
        check(16'(got), 16'(want));
        if (want && !got) final_report();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(6);
        srst_i <= 1'b0;
        @(posedge clk_i);
        // Cleared registers, plus one unmapped index
        foreach (rst_ofs[i]) begin
            rd(rst_ofs[i], a);
            check(a, RST_WORD);
        end
        rd(OFS_TIMER, a);
        rd(OFS_TIMER, b);
        check(b - a, 16'h0002);
        // Multi-capture modes and the reserved code on every channel
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 6; k++) begin
                m = 4'hA + 4'(k);
                wr(OFS_MODE, 16'h0000);
                cyc(3);
                v = 16'($random(seed));
                wr(OFS_CC0 + 4'(c), v);
                wr(OFS_MODE, {4'h0, m, m, m});
                for (int t = 0; t < 16; t++) begin
                    pin_req[c] <= (t < 7);
                    pos_req[c] <= (t >= 3 && t < 12);
                    @(posedge clk_i);
                end
                cyc(4);
                rd(OFS_CC0 + 4'(c), a);
                rd(OFS_SHADOW0 + 4'(c), b);
                if (m == MODE_RSVD) check(a, v);
                else check(a - b, 16'(mt[k] - st[k]));
            end
        end
        // Hysteresis: compare sets state only while position is high
        wr(OFS_MODE, 16'h0999);
        for (int h = 0; h < 2; h++) begin
            pos_req <= 3'(h);
            rd(OFS_TIMER, a);
            wr(OFS_CC0, a + 16'd20);
            cyc(30);
            check(16'(chan_state_o[0]), 16'(h));
        end
        pos_req <= 3'h0;
        cyc(4);
        check(16'(chan_state_o[0]), 16'h0000);
        // Hall: valid event, phase delay and time-out
        wr(OFS_MODE, 16'h0000);
        pos_req <= 3'b001;
        cyc(4);
        wr(OFS_CC1, 16'h0010);
        wr(OFS_CC2, 16'h0020);
        wr(OFS_PATTERN, 16'h000b);
        wr(OFS_MODE, 16'h0888);
        cyc(4);
        pos_req <= 3'b011;
        wait_evt(0, 30, 1'b1, n);
        check(16'(n >= int'(DT) && n <= int'(DT) + 6), 16'h0001);
        rd(OFS_TIMER, a);
        check(16'(a < 16'h0008), 16'h0001);
        rd(OFS_PATTERN, a);
        check(16'(a[5:3]), 16'h0003);
        wait_evt(2, 30, 1'b1, n);
        wait_evt(3, 30, 1'b1, n);
        check(16'(n >= 12 && n <= 20), 16'h0001);
        // Pattern that matches neither current nor expected
        wr(OFS_PATTERN, 16'h001a);
        pos_req <= 3'b101;
        wait_evt(1, 30, 1'b1, n);
        // Only two fields in hall code: no hall activity
        wr(OFS_MODE, 16'h0088);
        wr(OFS_PATTERN, 16'h002c);
        pos_req <= 3'b100;
        wait_evt(0, 30, 1'b0, n);
        final_report();
    end
endmodule
